// >>> pkg/oisc_pkg.sv
// Operation
// - enable interlock acts only when setup switch nine is up.
// - interlock active and terminals open: output off, fault code, protection blink.
// - shorting terminals again recovers; auto restart resumes by itself.
// - safe start latches the interlock off until output-on press or clear.
// - power-good high with no fault, low while any fault present.
// - power-good low on ovp, ocp, otp, ac fail, interlock, shut-off, remote fail, output off. Code keeps it high while a safe start latch holds output off.
// - faulted unit lowers power-good and shows fault; downstream units show shut-off.
// - after chain fault clears each unit recovers per its own startup mode.
// - analog mode rejects knob and remote setpoint changes, readback still allowed.
// - switches one and two down: select ignored, indicator open, local control.
// - either switch up: select low chooses analog, indicator low; high chooses local.
// - switch three selects doubled analog programming range when up.
// - switches seven and eight select resistance programming for voltage and current.
// - switch four selects higher monitor output range when up.
// - analog setpoints accepted to a small margin above rated maximum.
// - safe start powers up with output off; auto restart restores saved settings.
package oisc_pkg;
	// ----------------------------------------
	// switch bank positions (bit set = up)
	// ----------------------------------------
	localparam int SW_REMOTE_V = 0;
	localparam int SW_REMOTE_I = 1;
	localparam int SW_PROG_RANGE = 2;
	localparam int SW_MON_RANGE = 3;
	localparam int SW_SO_POLARITY = 4;
	localparam int SW_RES_V = 6;
	localparam int SW_RES_I = 7;
	localparam int SW_INTERLOCK = 8;
	localparam logic [8:0] SW_RESET = 9'h000;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int DEBOUNCE_US = 5000;
	localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
	// setpoint margin above rated maximum, percent
	localparam int MARGIN_PCT = 5;
	localparam logic [15:0] RATED_MAX = 16'hFFFF / 16'h0069 * 16'h0064;
	localparam logic [15:0] SETPOINT_LIMIT = 16'(32'(RATED_MAX) * (100 + MARGIN_PCT) / 100);
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {OISC_SHOW_MEAS, OISC_SHOW_INTERLOCK, OISC_SHOW_SHUTOFF, OISC_SHOW_FAULT} oisc_disp_t;
	typedef struct packed {
		logic ovp;
		logic ocp;
		logic otp;
		logic ac_fail;
		logic shut_off;
		logic remote_fail;
	} oisc_faults_t;
	typedef struct packed {
		logic prog_range_high;
		logic mon_range_high;
		logic res_prog_v;
		logic res_prog_i;
		logic so_polarity_up;
	} oisc_cfg_t;
endpackage

// >>> design/oisc_debounce.sv
`timescale 1ns/10ps
module oisc_debounce #(
	parameter int CYCLES = 200000,
	parameter logic INIT = 1'b1
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// raw and clean level
	input wire logic raw_in,
	output logic clean_out
);
	logic sync1_r, sync1_nxt, sync2_r, sync2_nxt, clean_r, clean_nxt;
	logic [31:0] cnt_r, cnt_nxt;

	always_comb begin
		sync1_nxt = raw_in;
		sync2_nxt = sync1_r;
		clean_nxt = clean_r;
		cnt_nxt = 32'h0000_0000;
		if (sync2_r != clean_r) begin
			if (cnt_r >= 32'(CYCLES - 1)) begin
				clean_nxt = sync2_r;
			end else begin
				cnt_nxt = cnt_r + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sync1_r <= INIT;
			sync2_r <= INIT;
			clean_r <= INIT;
			cnt_r <= 32'h0000_0000;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			clean_r <= clean_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign clean_out = clean_r;
endmodule

// >>> design/oisc_ctrl.sv
`timescale 1ns/10ps
module oisc_ctrl #(
	parameter int DEBOUNCE_CYCLES = oisc_pkg::DEBOUNCE_CYC,
	parameter int BLINK_CYCLES = oisc_pkg::BLINK_CYC
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// setup switches and startup mode
	input wire logic [8:0] setup_switch_bank_in,
	input wire logic auto_restart_in,
	input wire logic saved_output_on_in,
	// rear connector
	input wire logic interlock_terminals_shorted_in,
	input wire logic analog_select_in,
	// front panel and remote
	input wire logic out_on_press_in,
	input wire logic prot_clear_in,
	input wire logic setpoint_write_in,
	input wire logic [15:0] setpoint_data_in,
	input wire logic analog_setpoint_valid_in,
	input wire logic [15:0] analog_setpoint_in,
	// fault sources
	input wire oisc_pkg::oisc_faults_t faults_in,
	// output control and status
	output logic output_enable_out,
	output logic power_good_out,
	output logic mode_ind_low_out,
	output logic mode_ind_oe_n_out,
	output logic analog_mode_out,
	output logic setpoint_reject_out,
	output logic [15:0] setpoint_out,
	output logic prot_blink_out,
	output logic interlock_fault_code_out,
	output oisc_pkg::oisc_disp_t display_out,
	output oisc_pkg::oisc_cfg_t cfg_out
);
	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	logic ilk_clean, sel_clean;

	oisc_debounce #(.CYCLES(DEBOUNCE_CYCLES), .INIT(1'b1)) u_ilk_db (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.raw_in(interlock_terminals_shorted_in),
		.clean_out(ilk_clean)
	);

	oisc_debounce #(.CYCLES(DEBOUNCE_CYCLES), .INIT(1'b1)) u_sel_db (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.raw_in(analog_select_in),
		.clean_out(sel_clean)
	);

	function automatic logic [15:0] clamp_sp(input logic [15:0] v);
		return (v > oisc_pkg::SETPOINT_LIMIT) ? oisc_pkg::SETPOINT_LIMIT : v;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [8:0] sw_r, sw_nxt;
	logic sw_taken_r, sw_taken_nxt;
	logic out_on_r, out_on_nxt;
	logic ilk_latch_r, ilk_latch_nxt;
	logic flt_latch_r, flt_latch_nxt;
	logic enable_r, enable_nxt;
	logic pgood_r, pgood_nxt;
	logic analog_r, analog_nxt;
	logic ind_low_r, ind_low_nxt;
	logic ind_oe_n_r, ind_oe_n_nxt;
	logic reject_r, reject_nxt;
	logic [15:0] sp_r, sp_nxt;
	logic blink_r, blink_nxt;
	logic ilk_code_r, ilk_code_nxt;
	oisc_pkg::oisc_disp_t disp_r, disp_nxt;
	oisc_pkg::oisc_cfg_t cfg_r, cfg_nxt;
	logic [31:0] blink_cnt_r, blink_cnt_nxt;

	logic ilk_on, ilk_open, ilk_block, fault_now, fault_block, sel_enabled, prot_blink;
	logic clr_req;

	always_comb begin
		ilk_on = sw_r[oisc_pkg::SW_INTERLOCK];
		ilk_open = ilk_on && !ilk_clean;
		clr_req = out_on_press_in || prot_clear_in;
		fault_now = |faults_in;
		sel_enabled = sw_r[oisc_pkg::SW_REMOTE_V] || sw_r[oisc_pkg::SW_REMOTE_I];

		sw_nxt = sw_r;
		sw_taken_nxt = 1'b1;
		if (!sw_taken_r) begin
			sw_nxt = setup_switch_bank_in;
		end

		// safe start latches; auto restart follows the level
		ilk_latch_nxt = ilk_latch_r;
		if (ilk_open) begin
			ilk_latch_nxt = 1'b1;
		end else if (auto_restart_in || clr_req) begin
			ilk_latch_nxt = 1'b0;
		end
		flt_latch_nxt = flt_latch_r;
		if (fault_now) begin
			flt_latch_nxt = 1'b1;
		end else if (auto_restart_in || clr_req) begin
			flt_latch_nxt = 1'b0;
		end
		ilk_block = ilk_open || ilk_latch_r;
		fault_block = fault_now || flt_latch_r;

		out_on_nxt = out_on_r;
		if (!sw_taken_r) begin
			out_on_nxt = auto_restart_in ? saved_output_on_in : 1'b0;
		end else if (out_on_press_in && !ilk_block && !fault_block) begin
			out_on_nxt = !out_on_r;
		end else if (out_on_press_in && (ilk_latch_r || flt_latch_r) && !ilk_open && !fault_now) begin
			out_on_nxt = 1'b1;
		end

		enable_nxt = sw_taken_r && out_on_r && !ilk_block && !fault_block;
		// any present fault, open interlock or output switched off drops power-good; the safe start latches alone do not
		pgood_nxt = sw_taken_r && out_on_r && !ilk_open && !fault_now;

		prot_blink = ilk_block;
		blink_cnt_nxt = 32'h0000_0000;
		blink_nxt = 1'b0;
		if (prot_blink) begin
			blink_nxt = blink_r;
			blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
			if (blink_cnt_r >= 32'(BLINK_CYCLES - 1)) begin
				blink_cnt_nxt = 32'h0000_0000;
				blink_nxt = !blink_r;
			end
		end
		ilk_code_nxt = ilk_block;

		case (1'b1)
			ilk_block: disp_nxt = oisc_pkg::OISC_SHOW_INTERLOCK;
			fault_block && faults_in.shut_off: disp_nxt = oisc_pkg::OISC_SHOW_SHUTOFF;
			fault_block: disp_nxt = oisc_pkg::OISC_SHOW_FAULT;
			default: disp_nxt = oisc_pkg::OISC_SHOW_MEAS;
		endcase

		analog_nxt = sel_enabled && !sel_clean;
		ind_low_nxt = 1'b0;
		ind_oe_n_nxt = !analog_nxt;

		reject_nxt = analog_r && setpoint_write_in;
		sp_nxt = sp_r;
		if (analog_r) begin
			if (analog_setpoint_valid_in) begin
				sp_nxt = clamp_sp(analog_setpoint_in);
			end
		end else if (setpoint_write_in) begin
			sp_nxt = clamp_sp(setpoint_data_in);
		end

		cfg_nxt.prog_range_high = sw_r[oisc_pkg::SW_PROG_RANGE];
		cfg_nxt.mon_range_high = sw_r[oisc_pkg::SW_MON_RANGE];
		cfg_nxt.res_prog_v = sw_r[oisc_pkg::SW_RES_V];
		cfg_nxt.res_prog_i = sw_r[oisc_pkg::SW_RES_I];
		// daisy chain needs this low on every unit
		cfg_nxt.so_polarity_up = sw_r[oisc_pkg::SW_SO_POLARITY];
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sw_r <= oisc_pkg::SW_RESET;
			sw_taken_r <= 1'b0;
			out_on_r <= 1'b0;
			ilk_latch_r <= 1'b0;
			flt_latch_r <= 1'b0;
			enable_r <= 1'b0;
			pgood_r <= 1'b0;
			analog_r <= 1'b0;
			ind_low_r <= 1'b0;
			ind_oe_n_r <= 1'b1;
			reject_r <= 1'b0;
			sp_r <= 16'h0000;
			blink_r <= 1'b0;
			ilk_code_r <= 1'b0;
			disp_r <= oisc_pkg::OISC_SHOW_MEAS;
			cfg_r <= '0;
			blink_cnt_r <= 32'h0000_0000;
		end else begin
			sw_r <= sw_nxt;
			sw_taken_r <= sw_taken_nxt;
			out_on_r <= out_on_nxt;
			ilk_latch_r <= ilk_latch_nxt;
			flt_latch_r <= flt_latch_nxt;
			enable_r <= enable_nxt;
			pgood_r <= pgood_nxt;
			analog_r <= analog_nxt;
			ind_low_r <= ind_low_nxt;
			ind_oe_n_r <= ind_oe_n_nxt;
			reject_r <= reject_nxt;
			sp_r <= sp_nxt;
			blink_r <= blink_nxt;
			ilk_code_r <= ilk_code_nxt;
			disp_r <= disp_nxt;
			cfg_r <= cfg_nxt;
			blink_cnt_r <= blink_cnt_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign output_enable_out = enable_r;
	assign power_good_out = pgood_r;
	assign mode_ind_low_out = ind_low_r;
	assign mode_ind_oe_n_out = ind_oe_n_r;
	assign analog_mode_out = analog_r;
	assign setpoint_reject_out = reject_r;
	assign setpoint_out = sp_r;
	assign prot_blink_out = blink_r;
	assign interlock_fault_code_out = ilk_code_r;
	assign display_out = disp_r;
	assign cfg_out = cfg_r;
endmodule

// >>> tb/oisc_contact.sv
`timescale 1ns/10ps
module oisc_contact (
	// clock
	input wire logic ref_clk_in,
	// request and contact
	input wire logic close_in,
	output logic closed_out
);
	// a real contact chatters before it settles
	logic [1:0] bnc_r = 2'h0;
	logic last_r = 1'b1;
	initial closed_out = 1'b1;
	always @(posedge ref_clk_in) begin
		if (close_in != last_r) bnc_r <= 2'h3;
		else if (bnc_r != 2'h0) bnc_r <= bnc_r - 2'h1;
		last_r <= close_in;
		closed_out <= (bnc_r != 2'h0) ? ~closed_out : last_r;
	end
endmodule

// >>> tb/oisc_sva.sv
`timescale 1ns/10ps
module oisc_sva #(
	parameter int BLINK_CYCLES = 4
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// inputs
	input wire oisc_pkg::oisc_faults_t faults_in,
	input wire logic setpoint_write_in,
	input wire logic [15:0] setpoint_data_in,
	input wire logic analog_setpoint_valid_in,
	// outputs
	input wire logic output_enable_out,
	input wire logic power_good_out,
	input wire logic mode_ind_low_out,
	input wire logic mode_ind_oe_n_out,
	input wire logic analog_mode_out,
	input wire logic setpoint_reject_out,
	input wire logic [15:0] setpoint_out,
	input wire logic prot_blink_out,
	input wire logic interlock_fault_code_out
);
	localparam int BLINK_MAX = 2 * BLINK_CYCLES + 2;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_trip; $rose(interlock_fault_code_out); endsequence
	property p_ilk_off; s_trip |-> !output_enable_out && !power_good_out; endproperty
	a_ilk_off: assert property (p_ilk_off) else $error("trip left output on");
	property p_blink; s_trip |-> ##[1:BLINK_MAX] $changed(prot_blink_out); endproperty
	a_blink: assert property (p_blink) else $error("no blink");
	property p_pg_fault; (faults_in != '0) |-> ##[1:3] !power_good_out; endproperty
	a_pg_fault: assert property (p_pg_fault) else $error("pgood high on fault");
	property p_pg_off; $fell(output_enable_out) |-> ##[0:1] !power_good_out; endproperty
	a_pg_off: assert property (p_pg_off) else $error("pgood high with output off");
	property p_ind; mode_ind_oe_n_out == !analog_mode_out; endproperty
	a_ind: assert property (p_ind) else $error("indicator disagrees");
	property p_ind_low; mode_ind_low_out == 1'b0; endproperty
	a_ind_low: assert property (p_ind_low) else $error("indicator drives high");
	property p_rej; setpoint_write_in && analog_mode_out |=> setpoint_reject_out; endproperty
	a_rej: assert property (p_rej) else $error("no reject");
	property p_hold; analog_mode_out && setpoint_write_in && !analog_setpoint_valid_in |=> $stable(setpoint_out);
	endproperty
	a_hold: assert property (p_hold) else $error("setpoint moved");
	property p_wr; setpoint_write_in && !analog_mode_out && setpoint_data_in <= oisc_pkg::SETPOINT_LIMIT
		|=> setpoint_out == $past(setpoint_data_in); endproperty
	a_wr: assert property (p_wr) else $error("local write lost");
endmodule
bind oisc_ctrl oisc_sva #(.BLINK_CYCLES(BLINK_CYCLES)) u_sva (.ref_clk_in, .reset_in, .faults_in,
	.setpoint_write_in, .setpoint_data_in, .analog_setpoint_valid_in, .output_enable_out, .power_good_out,
	.mode_ind_low_out, .mode_ind_oe_n_out, .analog_mode_out, .setpoint_reject_out, .setpoint_out,
	.prot_blink_out, .interlock_fault_code_out);

// >>> tb/tb_output_interlock_status_ctrl.sv
`timescale 1ns/10ps
module tb_output_interlock_status_ctrl;
	localparam logic [15:0] LIM = oisc_pkg::SETPOINT_LIMIT;
	logic ref_clk_in = 0;
	logic reset_in = 1;
	logic auto_restart_in = 0;
	logic saved_output_on_in = 1;
	logic out_on_press_in = 0;
	logic prot_clear_in = 0;
	logic setpoint_write_in = 0;
	logic analog_setpoint_valid_in = 0;
	logic ilk_want = 1;
	logic sel_want = 0;
	logic sel_closed, interlock_terminals_shorted_in, analog_select_in;
	logic [8:0] setup_switch_bank_in = 9'h144;
	logic [15:0] setpoint_data_in = 16'h0000;
	logic [15:0] analog_setpoint_in = 16'h0000;
	oisc_pkg::oisc_faults_t faults_in = '0;
	logic output_enable_out, power_good_out, mode_ind_low_out, mode_ind_oe_n_out;
	logic analog_mode_out, setpoint_reject_out, prot_blink_out, interlock_fault_code_out;
	logic [15:0] setpoint_out;
	oisc_pkg::oisc_disp_t display_out;
	oisc_pkg::oisc_cfg_t cfg_out;
	int fails = 0;
	int total_checks = 0;
	always #12.5 ref_clk_in = ~ref_clk_in;
	// select contact closed means analog request
	assign analog_select_in = ~sel_closed;
	oisc_contact ilk (.ref_clk_in, .close_in(ilk_want), .closed_out(interlock_terminals_shorted_in));
	oisc_contact sel (.ref_clk_in, .close_in(sel_want), .closed_out(sel_closed));
	oisc_ctrl #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(4)) uut (.ref_clk_in, .reset_in, .setup_switch_bank_in,
		.auto_restart_in, .saved_output_on_in, .interlock_terminals_shorted_in, .analog_select_in,
		.out_on_press_in, .prot_clear_in, .setpoint_write_in, .setpoint_data_in, .analog_setpoint_valid_in,
		.analog_setpoint_in, .faults_in, .output_enable_out, .power_good_out, .mode_ind_low_out,
		.mode_ind_oe_n_out, .analog_mode_out, .setpoint_reject_out, .setpoint_out, .prot_blink_out,
		.interlock_fault_code_out, .display_out, .cfg_out);
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wait_en(input logic v);
		int i;
		for (i = 0; i < 80 && output_enable_out !== v; i++) cyc(1);
		if (i == 80) begin
			fails++;
			$display("[ERR] %0t enable wait timed out", $time);
			wrap_up();
		end else begin
			cyc(2);
		end
	endtask
	task automatic press(input logic clr);
		@(posedge ref_clk_in);
		prot_clear_in <= clr;
		out_on_press_in <= ~clr;
		@(posedge ref_clk_in);
		prot_clear_in <= 0;
		out_on_press_in <= 0;
	endtask
	task automatic rst(input logic [8:0] sw, input logic ar);
		@(posedge ref_clk_in);
		reset_in <= 1;
		setup_switch_bank_in <= sw;
		auto_restart_in <= ar;
		repeat (3) @(posedge ref_clk_in);
		reset_in <= 0;
		cyc(3);
	endtask
	task automatic wr(input logic ana, input logic [15:0] d);
		@(posedge ref_clk_in);
		setpoint_write_in <= ~ana;
		analog_setpoint_valid_in <= ana;
		setpoint_data_in <= d;
		analog_setpoint_in <= d;
		@(posedge ref_clk_in);
		setpoint_write_in <= 0;
		analog_setpoint_valid_in <= 0;
		cyc(1);
	endtask
	initial begin
		int i;
		rst(9'h144, 0);
		chk(cfg_out, 5'h14);
		chk(output_enable_out, 0);
		chk(power_good_out, 0);
		@(posedge ref_clk_in) setup_switch_bank_in <= 9'h1ff;
		press(0);
		wait_en(1);
		chk(power_good_out, 1);
		chk(cfg_out, 5'h14);
		@(posedge ref_clk_in) ilk_want <= 0;
		wait_en(0);
		chk(interlock_fault_code_out, 1);
		chk(display_out, oisc_pkg::OISC_SHOW_INTERLOCK);
		@(posedge ref_clk_in) ilk_want <= 1;
		cyc(30);
		chk(output_enable_out, 0);
		press(1);
		wait_en(1);
		$display("test safe start interlock done");
		@(posedge ref_clk_in) faults_in <= 6'h08;
		wait_en(0);
		@(posedge ref_clk_in) faults_in <= '0;
		cyc(30);
		chk(output_enable_out, 0);
		press(0);
		wait_en(1);
		@(posedge ref_clk_in) auto_restart_in <= 1;
		for (i = 0; i < 6; i++) begin
			@(posedge ref_clk_in) faults_in <= oisc_pkg::oisc_faults_t'(6'h01 << i);
			wait_en(0);
			chk(power_good_out, 0);
			chk(display_out, (i == 1) ? oisc_pkg::OISC_SHOW_SHUTOFF : oisc_pkg::OISC_SHOW_FAULT);
			@(posedge ref_clk_in) faults_in <= '0;
			wait_en(1);
			chk(power_good_out, 1);
			chk(display_out, oisc_pkg::OISC_SHOW_MEAS);
		end
		@(posedge ref_clk_in) ilk_want <= 0;
		wait_en(0);
		@(posedge ref_clk_in) ilk_want <= 1;
		wait_en(1);
		chk(output_enable_out, 1);
		$display("test faults and auto restart done");
		rst(9'h001, 1);
		chk(output_enable_out, 1);
		@(posedge ref_clk_in) ilk_want <= 0;
		sel_want <= 1;
		cyc(30);
		chk(output_enable_out, 1);
		chk(mode_ind_oe_n_out, 0);
		wr(1, LIM);
		chk(setpoint_out, LIM);
		// beyond the margin the setpoint is held at the limit
		wr(1, 16'hFFFF);
		chk(setpoint_out, LIM);
		wr(0, 16'h1234);
		chk(setpoint_reject_out, 1);
		chk(setpoint_out, LIM);
		@(posedge ref_clk_in) sel_want <= 0;
		cyc(30);
		wr(0, 16'h1234);
		chk(setpoint_out, 16'h1234);
		rst(9'h000, 1);
		@(posedge ref_clk_in) sel_want <= 1;
		cyc(30);
		chk(mode_ind_oe_n_out, 1);
		chk(analog_mode_out, 0);
		$display("test mode select done");
		wrap_up();
	end
endmodule
